//--- rtl/gpio_port.sv
// Grouped open-drain digital line port with edge capture and overflow outputs
// Operation
// - 48 lines in three groups of 16; line = group*16 + bit.
// - Group access is a 16-bit word; bit 0 is the group's lowest line.
// - Logical one pulls the pin low; zero releases it.
// - Software sees inverted pin sense: low pin reads as one.
// - Lines 0 to 5 each have a standard or overflow mode bit.
// - Overflow mode routes counters 0A,0B,1A,1B,2A,2B to lines 0 to 5.
// - Each overflow gives exactly one 500 ns active pulse; an overflow during a pulse reloads it, so the two give one longer pulse.
// - Mode readback is zero for standard, non-zero for overflow.
// - Output readback returns driver states, untouched by the pins.
// - Input readback returns the logical pin states of the group.
// - Polarity bit zero captures falling, one captures rising logical edges.
// - Capture exists on lines 0 to 39; writes above are ignored.
// - A capture flag may set only while its enable is one.
// - Selected edge sets the flag and, if enabled, an interrupt request.
// - Clearing capture enable clears the flag and its request.
// - Capture reset with a one clears flag and request; zero keeps it. An enabled edge in the same cycle leaves the flag set.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module gpio_port
    import gpio_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // Register port
    input  wire logic [ADDR_W-1:0]      addr,
    input  wire logic [DATA_W-1:0]      wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [DATA_W-1:0]      rdata,
    // Open-drain lines
    input  wire logic [NUM_LINES-1:0]   line_i,
    output logic      [NUM_LINES-1:0]   line_o,
    output logic      [NUM_LINES-1:0]   line_oe,
    // Counter overflow events
    input  wire logic [DUAL_LINES-1:0]  ovf_evt,
    // Per-line capture requests
    output logic      [CAP_LINES-1:0]   irq_req
);
    typedef struct packed {
        logic [NUM_LINES-1:0]  out;
        logic [DUAL_LINES-1:0] mode;
        logic [CAP_LINES-1:0]  edge_sel;
        logic [CAP_LINES-1:0]  capen;
        logic [CAP_LINES-1:0]  capflag;
        logic [CAP_LINES-1:0]  inten;
        logic [NUM_LINES-1:0]  prev;
        logic [DATA_W-1:0]     rdata;
    } port_st_t;

    localparam port_st_t ST_RST = '{
        out:      LINE_RST,
        mode:     MODE_RST,
        edge_sel: CAP_RST,
        capen:    CAP_RST,
        capflag:  CAP_RST,
        inten:    CAP_RST,
        prev:     LINE_RST,
        rdata:    WORD_RST
    };

    localparam logic [7:0]  CAP_PAD  = 8'h00;
    localparam logic [9:0]  MODE_PAD = 10'h000;

    // Group word extraction, bit 0 is the group's lowest line
    function automatic logic [DATA_W-1:0] get_grp(input logic [NUM_LINES-1:0] v,
                                                  input logic [1:0]           g);
        logic [DATA_W-1:0] w;
        w = WORD_RST;
        case (g)
            2'h0:    w = v[15:0];
            2'h1:    w = v[31:16];
            2'h2:    w = v[47:32];
            default: w = WORD_RST;
        endcase
        return w;
    endfunction

    // Replace one group word inside a line vector
    function automatic logic [NUM_LINES-1:0] put_grp(input logic [NUM_LINES-1:0] v,
                                                     input logic [1:0]           g,
                                                     input logic [DATA_W-1:0]    w);
        logic [NUM_LINES-1:0] r;
        r = v;
        case (g)
            2'h0:    r[15:0]  = w;
            2'h1:    r[31:16] = w;
            2'h2:    r[47:32] = w;
            default: r = v;
        endcase
        return r;
    endfunction

    port_st_t              st_ff;
    port_st_t              nxt_st;
    line_sync_if #(.WIDTH(NUM_LINES)) sync_bus ();

    logic [2:0]            fn;
    logic [1:0]            grp;
    logic                  grp_ok;
    logic [NUM_LINES-1:0]  cur;
    logic [NUM_LINES-1:0]  spread;
    logic [NUM_LINES-1:0]  wr_edge;
    logic [NUM_LINES-1:0]  wr_inten;
    logic [CAP_LINES-1:0]  rise;
    logic [CAP_LINES-1:0]  fall;
    logic [CAP_LINES-1:0]  hit;
    logic [CAP_LINES-1:0]  cap_clr;
    logic [DUAL_LINES-1:0] ovf_line;

    assign sync_bus.raw = line_i;

    line_sync u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .lines   (sync_bus.sync_side)
    );

    // One pulse stretcher per counter channel
    genvar gi;
    generate
        for (gi = 0; gi < DUAL_LINES; gi++) begin : g_ovf
            ovf_pulse #(
                .WIDTH_CYC (PULSE_CYC)
            ) u_pulse (
                .clk_sys (clk_sys),
                .rst     (rst),
                .trig    (ovf_evt[gi]),
                .pulse_o (ovf_line[gi])
            );
        end
    endgenerate

    assign fn     = addr[FN_MSB:FN_LSB];
    assign grp    = addr[GRP_MSB:GRP_LSB];
    assign grp_ok = (grp <= GRP_LAST);

    assign cur = ~sync_bus.sync;

    // Write word placed on its group's lines
    assign spread   = put_grp(LINE_RST, grp, wdata);
    assign wr_edge  = put_grp({CAP_PAD, st_ff.edge_sel}, grp, wdata);
    assign wr_inten = put_grp({CAP_PAD, st_ff.inten}, grp, wdata);

    assign rise = cur[CAP_LINES-1:0] & ~st_ff.prev[CAP_LINES-1:0];
    assign fall = ~cur[CAP_LINES-1:0] & st_ff.prev[CAP_LINES-1:0];

    assign hit = (st_ff.edge_sel & rise) | (~st_ff.edge_sel & fall);

    always_comb begin
        nxt_st  = st_ff;
        cap_clr = CAP_RST;

        if (wr && grp_ok) begin
            case (fn)
                FN_OUT: begin
                    nxt_st.out = put_grp(st_ff.out, grp, wdata);
                end
                FN_EDGE: begin
                    nxt_st.edge_sel = wr_edge[CAP_LINES-1:0];
                end
                FN_CAP_SET: begin
                    nxt_st.capen = st_ff.capen | spread[CAP_LINES-1:0];
                end
                FN_CAP_CLR: begin
                    nxt_st.capen = st_ff.capen & ~spread[CAP_LINES-1:0];
                end
                // Ones clear flags, zeros keep them
                FN_CAPSTAT: begin
                    cap_clr = spread[CAP_LINES-1:0];
                end
                FN_INTEN: begin
                    nxt_st.inten = wr_inten[CAP_LINES-1:0];
                end
                // Mode bits for lines 0 to 5
                FN_MODE: begin
                    nxt_st.mode = wdata[DUAL_LINES-1:0];
                end
                default: begin
                    nxt_st.mode = st_ff.mode;
                end
            endcase
        end

        // Set wins over reset; disabled lines hold no flag
        nxt_st.capflag = ((st_ff.capflag & ~cap_clr) | (hit & st_ff.capen)) & nxt_st.capen;
        nxt_st.prev    = cur;

        // Read data valid in the cycle after the strobe
        nxt_st.rdata = WORD_RST;
        if (rd && grp_ok) begin
            case (fn)
                FN_OUT: begin
                    nxt_st.rdata = get_grp(st_ff.out, grp);
                end
                FN_IN: begin
                    nxt_st.rdata = get_grp(cur, grp);
                end
                FN_EDGE: begin
                    nxt_st.rdata = get_grp({CAP_PAD, st_ff.edge_sel}, grp);
                end
                FN_CAP_SET: begin
                    nxt_st.rdata = get_grp({CAP_PAD, st_ff.capen}, grp);
                end
                FN_CAP_CLR: begin
                    nxt_st.rdata = get_grp({CAP_PAD, st_ff.capen}, grp);
                end
                FN_CAPSTAT: begin
                    nxt_st.rdata = get_grp({CAP_PAD, st_ff.capflag}, grp);
                end
                FN_INTEN: begin
                    nxt_st.rdata = get_grp({CAP_PAD, st_ff.inten}, grp);
                end
                FN_MODE: begin
                    nxt_st.rdata = {MODE_PAD, st_ff.mode};
                end
                default: begin
                    nxt_st.rdata = WORD_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Open drain: only ever drive low
    assign line_o = LINE_RST;

    // Overflow pulse replaces the driver on dual lines
    always_comb begin
        line_oe = st_ff.out;
        for (int i = 0; i < DUAL_LINES; i++) begin
            line_oe[i] = st_ff.mode[i] ? ovf_line[i] : st_ff.out[i];
        end
    end

    // Request while flag and enable are both set
    assign irq_req = st_ff.capflag & st_ff.inten;
    assign rdata   = st_ff.rdata;

    a_grp_write_drive: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == {FN_OUT, 2'h1}) |=> (line_oe[31:16] == $past(wdata)))
        else $error("group write did not reach all drivers");

    a_out_read_back: assert property (@(posedge clk_sys) disable iff (rst)
        (rd && addr == {FN_OUT, 2'h2}) |=> (rdata == $past(st_ff.out[47:32])))
        else $error("output readback mismatch");

    a_in_read_sense: assert property (@(posedge clk_sys) disable iff (rst)
        (rd && addr == {FN_IN, 2'h0}) |=> (rdata == ~$past(sync_bus.sync[15:0])))
        else $error("input readback not inverted pin sense");

    a_std_mode_drive: assert property (@(posedge clk_sys) disable iff (rst)
        !st_ff.mode[2] |-> (line_oe[2] == st_ff.out[2]))
        else $error("standard mode line not following driver");

    a_ovf_mode_route: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff.mode[4] && ovf_evt[4]) |=> line_oe[4] [*3])
        else $error("overflow pulse not routed to its line");

    a_flag_needs_en: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff.capflag & ~st_ff.capen) == CAP_RST)
        else $error("capture flag set while disabled");

    a_edge_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (hit[3] && st_ff.capen[3] && !(wr && fn == FN_CAP_CLR)) |=> st_ff.capflag[3])
        else $error("enabled edge did not set its flag");

    a_capen_clr_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == {FN_CAP_CLR, 2'h0}) |=> ((irq_req[15:0] & $past(wdata)) == WORD_RST))
        else $error("disable did not clear request");

    a_cap_reset_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == {FN_CAPSTAT, 2'h1} && (hit[31:16] == WORD_RST))
        |=> ((st_ff.capflag[31:16] & $past(wdata)) == WORD_RST))
        else $error("capture reset did not clear flag");

    a_high_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        (rd && addr == {FN_EDGE, 2'h2}) |=> (rdata[15:8] == CAP_PAD))
        else $error("capture bits above line 39 not ignored");

    a_reset_released: assert property (@(posedge clk_sys)
        rst |=> (line_oe == LINE_RST && irq_req == CAP_RST))
        else $error("lines not released after reset");
endmodule

`default_nettype wire

//--- rtl/gpio_pkg.sv
// Shared constants for the grouped open-drain digital line port
package gpio_pkg;

    // Line organisation
    localparam int NUM_LINES  = 48;
    localparam int GRP_W      = 16;
    localparam int NUM_GRP    = 3;
    localparam int CAP_LINES  = 40;
    localparam int DUAL_LINES = 6;

    // Register port widths
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // Address layout: function in addr[4:2], group in addr[1:0]
    localparam int FN_LSB  = 2;
    localparam int FN_MSB  = 4;
    localparam int GRP_LSB = 0;
    localparam int GRP_MSB = 1;

    localparam logic [1:0] GRP_LAST = 2'h2;

    // Function codes
    localparam logic [2:0] FN_OUT     = 3'h0;
    localparam logic [2:0] FN_IN      = 3'h1;
    localparam logic [2:0] FN_EDGE    = 3'h2;
    localparam logic [2:0] FN_CAP_SET = 3'h3;
    localparam logic [2:0] FN_CAP_CLR = 3'h4;
    localparam logic [2:0] FN_CAPSTAT = 3'h5;
    localparam logic [2:0] FN_INTEN   = 3'h6;
    localparam logic [2:0] FN_MODE    = 3'h7;

    // Reset values
    localparam logic [47:0] LINE_RST = 48'h0;
    localparam logic [39:0] CAP_RST  = 40'h0;
    localparam logic [5:0]  MODE_RST = 6'h0;
    localparam logic [15:0] WORD_RST = 16'h0;

    // Overflow pulse timing
    localparam int PULSE_NS  = 500;
    localparam int CLK_KHZ   = 40000;
    localparam int PULSE_CYC = (PULSE_NS * CLK_KHZ) / 1000000;

endpackage

//--- rtl/line_sync_if.sv
// Carrier between the port core and its pin synchroniser
`timescale 1ns/1ps
`default_nettype none

interface line_sync_if #(
    parameter int WIDTH = 48
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] sync;

    modport sync_side (
        input  raw,
        output sync
    );

    modport core_side (
        output raw,
        input  sync
    );
endinterface

`default_nettype wire

//--- rtl/line_sync.sv
// Two-stage synchroniser for the line pin inputs
`timescale 1ns/1ps
`default_nettype none

module line_sync
    import gpio_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst,
    // Pin side and core side
    line_sync_if.sync_side     lines
);
    typedef struct packed {
        logic [NUM_LINES-1:0] meta;
        logic [NUM_LINES-1:0] stable;
    } sync_st_t;

    sync_st_t sync_ff;
    sync_st_t nxt_sync;

    always_comb begin
        nxt_sync        = sync_ff;
        nxt_sync.meta   = lines.raw;
        nxt_sync.stable = sync_ff.meta;
    end

    // Pins idle high, so reset to released
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_ff <= {~LINE_RST, ~LINE_RST};
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign lines.sync = sync_ff.stable;
endmodule

`default_nettype wire

//--- rtl/ovf_pulse.sv
// Fixed-width pulse stretcher for one counter overflow event
`timescale 1ns/1ps
`default_nettype none

module ovf_pulse
    import gpio_pkg::*;
#(
    parameter int WIDTH_CYC = PULSE_CYC
)(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Event and pulse
    input  wire logic trig,
    output logic      pulse_o
);
    typedef struct packed {
        logic [7:0] cnt;
    } pulse_st_t;

    localparam logic [7:0] CNT_LOAD = 8'(WIDTH_CYC);
    localparam logic [7:0] CNT_ONE  = 8'h01;
    localparam logic [7:0] CNT_ZERO = 8'h00;

    pulse_st_t pulse_ff;
    pulse_st_t nxt_pulse;

    always_comb begin
        nxt_pulse = pulse_ff;
        if (trig) begin
            nxt_pulse.cnt = CNT_LOAD;
        end else if (pulse_ff.cnt != CNT_ZERO) begin
            nxt_pulse.cnt = pulse_ff.cnt - CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pulse_ff <= '{cnt: 8'h00};
        end else begin
            pulse_ff <= nxt_pulse;
        end
    end

    assign pulse_o = (pulse_ff.cnt != CNT_ZERO);

    a_pulse_load_full: assert property (@(posedge clk_sys) disable iff (rst)
        trig |=> pulse_o [*8] ##0 (pulse_ff.cnt == CNT_LOAD - 8'h07))
        else $error("overflow pulse not loaded to full width");

    a_pulse_ends_width: assert property (@(posedge clk_sys) disable iff (rst)
        (pulse_ff.cnt == CNT_ONE && !trig) |=> !pulse_o)
        else $error("overflow pulse did not end on time");
endmodule

`default_nettype wire

//--- sim/wired_lines.sv
// External wired-OR line model with passive pull-ups
`timescale 1ns/1ps
`default_nettype none

module wired_lines
    import gpio_pkg::*;
(
    // Board drivers, high pulls the pin low
    input  wire logic [NUM_LINES-1:0] line_oe,
    // External sources pulling lines low
    input  wire logic [NUM_LINES-1:0] ext_pull,
    // Resolved pin levels
    output logic      [NUM_LINES-1:0] line_i
);
    assign line_i = ~(line_oe | ext_pull);
endmodule

`default_nettype wire

//--- sim/testbench.sv
// Self-checking testbench for the grouped open-drain line port
`timescale 1ns/1ps
`default_nettype none

module testbench
    import gpio_pkg::*;
;
    logic                  clk_sys    = 1'h0;
    logic                  rst        = 1'h1;
    logic [ADDR_W-1:0]     addr       = 5'h00;
    logic [DATA_W-1:0]     wdata      = 16'h0000;
    logic                  wr         = 1'h0;
    logic                  rd         = 1'h0;
    logic [DUAL_LINES-1:0] ovf_evt    = 6'h00;
    logic [NUM_LINES-1:0]  ext_pull   = 48'h0;
    logic [DATA_W-1:0]     rdata;
    logic [NUM_LINES-1:0]  line_i;
    logic [NUM_LINES-1:0]  line_o;
    logic [NUM_LINES-1:0]  line_oe;
    logic [CAP_LINES-1:0]  irq_req;
    logic [NUM_LINES-1:0]  exp_oe     = 48'h0;
    int                    n_errors   = 0;
    int                    n_compared = 0;
    int                    seed       = 32'hd4607238;

    always #12.5 clk_sys = ~clk_sys;

    gpio_port i_gpio_port (
        .clk_sys (clk_sys),
        .rst     (rst),
        .addr    (addr),
        .wdata   (wdata),
        .wr      (wr),
        .rd      (rd),
        .rdata   (rdata),
        .line_i  (line_i),
        .line_o  (line_o),
        .line_oe (line_oe),
        .ovf_evt (ovf_evt),
        .irq_req (irq_req)
    );

    wired_lines i_wired_lines (
        .line_oe  (line_oe),
        .ext_pull (ext_pull),
        .line_i   (line_i)
    );

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Logical pin state seen when board driver and outside source share a line
    function automatic logic [15:0] pins_seen(input logic [15:0] drv, input logic [15:0] ext);
        return drv | ext;
    endfunction

    task automatic wr_reg(input logic [2:0] fn, input logic [1:0] g, input logic [15:0] d);
        @(posedge clk_sys);
        addr  <= {fn, g};
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clk_sys);
        wr    <= 1'h0;
    endtask

    task automatic rd_chk(input logic [2:0] fn, input logic [1:0] g, input logic [15:0] exp);
        @(posedge clk_sys);
        addr <= {fn, g};
        rd   <= 1'h1;
        @(posedge clk_sys);
        rd   <= 1'h0;
        #1;
        check(rdata, exp);
    endtask

    // Move one external source, then let synchroniser and capture settle
    task automatic set_pin(input int l, input logic v);
        @(posedge clk_sys);
        ext_pull[l] <= v;
        repeat (5) @(posedge clk_sys);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys);
        n_errors++;
        $display("BAD at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        logic [15:0] w;
        logic [15:0] m;
        logic [2:0]  fns [3];
        int          ln;
        int          cnt;
        fns = '{FN_EDGE, FN_CAP_SET, FN_INTEN};
        repeat (5) @(posedge clk_sys);
        rst <= 1'h0;
        for (int f = 0; f < 8; f++)
            for (int g = 0; g < 4; g++)
                rd_chk(f[2:0], g[1:0], 16'h0000);
        check(line_oe, 48'h0);
        check(line_o, 48'h0);
        check({8'h00, irq_req}, 48'h0);
        $display("reset test done");

        for (int k = 0; k < 6; k++) begin
            for (int g = 0; g < 3; g++) begin
                w = $random(seed);
                m = $random(seed);
                wr_reg(FN_OUT, g[1:0], w);
                exp_oe[g*16 +: 16] = w;
                #1;
                check(line_oe, exp_oe);
                @(posedge clk_sys);
                ext_pull[g*16 +: 16] <= m;
                repeat (4) @(posedge clk_sys);
                rd_chk(FN_OUT, g[1:0], w);
                rd_chk(FN_IN, g[1:0], pins_seen(w, m));
            end
        end
        wr_reg(FN_OUT, 2'h3, 16'hFFFF);
        #1;
        check(line_oe, exp_oe);
        rd_chk(FN_OUT, 2'h3, 16'h0000);
        rd_chk(FN_IN, 2'h3, 16'h0000);
        $display("group test done");

        // Release every driver before using lines as inputs
        for (int g = 0; g < 3; g++)
            wr_reg(FN_OUT, g[1:0], 16'h0000);
        @(posedge clk_sys);
        ext_pull <= 48'h0;
        // Line 3 as a fixed corner, then a random capture line
        for (int t = 0; t < 2; t++) begin
        ln = (t == 0) ? 3 : $unsigned($random(seed)) % CAP_LINES;
        m = 16'h0001 << ln[3:0];
        for (int p = 0; p < 2; p++) begin
            set_pin(ln, p == 0);
            // Polarity goes in before the enable
            wr_reg(FN_EDGE, ln[5:4], p[0] ? m : 16'h0000);
            wr_reg(FN_CAP_SET, ln[5:4], m);
            wr_reg(FN_INTEN, ln[5:4], p[0] ? m : 16'h0000);
            set_pin(ln, p == 1);
            rd_chk(FN_CAPSTAT, ln[5:4], m);
            check(irq_req[ln], p[0]);
            wr_reg(FN_CAPSTAT, ln[5:4], ~m);
            rd_chk(FN_CAPSTAT, ln[5:4], m);
            wr_reg(FN_CAPSTAT, ln[5:4], m);
            rd_chk(FN_CAPSTAT, ln[5:4], 16'h0000);
            check(irq_req[ln], 1'h0);
            set_pin(ln, p == 0);
            rd_chk(FN_CAPSTAT, ln[5:4], 16'h0000);
            set_pin(ln, p == 1);
            rd_chk(FN_CAPSTAT, ln[5:4], m);
            wr_reg(FN_CAP_CLR, ln[5:4], m);
            rd_chk(FN_CAPSTAT, ln[5:4], 16'h0000);
            check(irq_req[ln], 1'h0);
            set_pin(ln, p == 0);
            set_pin(ln, p == 1);
            rd_chk(FN_CAPSTAT, ln[5:4], 16'h0000);
        end
        end
        for (int f = 0; f < 3; f++) begin
            wr_reg(fns[f], 2'h2, 16'hFFFF);
            rd_chk(fns[f], 2'h2, 16'h00FF);
        end
        wr_reg(FN_CAP_CLR, 2'h2, 16'hFFFF);
        $display("capture test done");

        for (int i = 0; i < 7; i++) begin
            m = (i < 6) ? (16'h0001 << i) : 16'h0000;
            wr_reg(FN_MODE, 2'(i % 3), m);
            rd_chk(FN_MODE, 2'h0, m);
            @(posedge clk_sys);
            ovf_evt <= 6'h01 << (i % 6);
            @(posedge clk_sys);
            ovf_evt <= 6'h00;
            cnt = 0;
            // Count only cycles where exactly the routed line is active
            repeat (PULSE_CYC + 10) begin
                #1;
                if (line_oe[5:0] === (6'h01 << (i % 6)))
                    cnt++;
                @(posedge clk_sys);
            end
            check(cnt, (i < 6) ? PULSE_CYC : 0);
        end
        $display("overflow test done");
        print_verdict();
    end
endmodule

`default_nettype wire
